/* File: logic/ihb_arbiter.sv */
`timescale 1ns/100ps
module ihb_arbiter
   import ihb_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic host_req,
   input wire logic refresh_req,
   output logic host_grant,
   output logic refresh_grant
);

   typedef struct packed {
      ihb_owner_t owner;
      logic last_host;
   } ihb_arb_regs_t;

   ihb_arb_regs_t r;
   ihb_arb_regs_t next_r;

   // ---------------------------------------------------------------------
   // Alternating grant
   // ---------------------------------------------------------------------
   // Alternation keeps a busy refresh from starving the host forever.
   always_comb
   begin
      next_r = r;
      unique case (r.owner)
         OWN_NONE:
         begin
            if (host_req && (!refresh_req || !r.last_host))
            begin
               next_r.owner = OWN_HOST;
               next_r.last_host = 1'b1;
            end
            else if (refresh_req)
            begin
               next_r.owner = OWN_REFRESH;
               next_r.last_host = 1'b0;
            end
         end
         OWN_HOST:
            if (!host_req)
               next_r.owner = OWN_NONE;
         OWN_REFRESH:
            if (!refresh_req)
               next_r.owner = OWN_NONE;
         default:
            next_r.owner = OWN_NONE;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         r <= '{owner: OWN_NONE, last_host: 1'b0};
      else
         r <= next_r;
   end

   assign host_grant = (r.owner == OWN_HOST) && host_req;
   assign refresh_grant = (r.owner == OWN_REFRESH) && refresh_req;

endmodule : ihb_arbiter

/* File: logic/ihb_device.sv */
// Our own choices: strobed register access and the address map.
`timescale 1ns/100ps
module ihb_device
   import ihb_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   ihb_if.device bus,
   input wire logic cfg_pin_0,
   input wire logic cfg_pin_1,
   input wire logic cfg_pin_2,
   input wire logic cfg_reserved_pin,
   input wire logic cfg_pin_4,
   input wire logic wait_polarity_cfg,
   input wire logic clock_ratio_cfg,
   input wire logic refresh_req,
   output logic refresh_grant,
   output logic core_req,
   output logic core_mem_sel,
   output logic core_write,
   output logic [ADDR_W-1:0] core_addr,
   output logic [1:0] core_lanes,
   output logic [DATA_W-1:0] core_wdata,
   input wire logic [DATA_W-1:0] core_rdata,
   input wire logic core_ack,
   output logic mode_ok,
   output logic cfg_taken
);

   typedef struct packed {
      logic cfg_taken;
      logic mode_ok;
      logic wait_hi;
      logic div2;
      logic phase;
      ihb_dev_state_t state;
      logic core_req;
      logic mem_sel;
      logic write;
      logic [ADDR_W-1:0] addr;
      logic [1:0] lanes;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic drive;
   } ihb_dev_regs_t;

   ihb_dev_regs_t r;
   ihb_dev_regs_t next_r;

   logic is_read;
   logic is_write;
   logic active;
   logic tick;
   logic host_req;
   logic host_grant;
   logic wait_active;
   logic [1:0] lanes_now;

   // ---------------------------------------------------------------------
   // Lane steering helpers
   // ---------------------------------------------------------------------
   // A lone odd byte travels on the low lane and lands in the high half.
   function automatic logic [DATA_W-1:0] steer_in(
      input logic [DATA_W-1:0] d,
      input logic [1:0] lanes);
      return (lanes == 2'h2) ? {d[7:0], d[7:0]} : d;
   endfunction : steer_in

   function automatic logic [DATA_W-1:0] steer_out(
      input logic [DATA_W-1:0] d,
      input logic [1:0] lanes);
      unique case (lanes)
         2'h1: return {8'h00, d[7:0]};
         2'h2: return {8'h00, d[15:8]};
         default: return d;
      endcase
   endfunction : steer_out

   // ---------------------------------------------------------------------
   // Access decode
   // ---------------------------------------------------------------------
   // Read and write strobe decode.
   assign is_write = !bus.low_byte_write_en_n && bus.read_en_n;
   assign is_read = !bus.read_en_n && bus.low_byte_write_en_n;
   assign active = r.mode_ok && !bus.chip_sel_n && (is_read || is_write);
   assign lanes_now = ihb_lanes(bus.high_byte_write_en_n, bus.addr_in[0]);
   assign tick = !r.div2 || r.phase;
   assign host_req = (r.state == DEV_ARB);

   // ---------------------------------------------------------------------
   // Arbitration against display refresh
   // ---------------------------------------------------------------------
   // Refresh arbitration.
   ihb_arbiter ihb_arbiter_inst (
      .clock(clock),
      .rst(rst),
      .host_req(host_req),
      .refresh_req(refresh_req),
      .host_grant(host_grant),
      .refresh_grant(refresh_grant)
   );

   // ---------------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.phase = r.div2 ? !r.phase : 1'b0;
      if (!r.cfg_taken)
      begin
         next_r.cfg_taken = 1'b1;
         next_r.mode_ok = ({cfg_pin_4, cfg_pin_2, cfg_pin_1, cfg_pin_0}
                           == MODE_GENERIC2_LE);
         next_r.wait_hi = wait_polarity_cfg;
         next_r.div2 = clock_ratio_cfg;
      end
      unique case (r.state)
         DEV_IDLE:
         begin
            next_r.drive = 1'b0;
            if (active && tick)
            begin
               next_r.state = DEV_ARB;
               next_r.mem_sel = bus.mem_reg_sel;
               next_r.write = is_write;
               next_r.addr = {bus.addr_in[ADDR_W-1:1], 1'b0};
               next_r.lanes = lanes_now;
               next_r.wdata = steer_in(bus.data_io, lanes_now);
            end
         end
         DEV_ARB:
         begin
            if (!active && !r.core_req)
               next_r.state = DEV_IDLE;
            else if (r.core_req && core_ack)
            begin
               next_r.core_req = 1'b0;
               next_r.rdata = steer_out(core_rdata, r.lanes);
               next_r.drive = !r.write;
               next_r.state = DEV_DONE;
            end
            else if (host_grant && tick)
               next_r.core_req = 1'b1;
         end
         DEV_DONE:
         begin
            // The strobe end is not gated by the tick, so a host that
            // starts the next cycle quickly is never mistaken for this one.
            if (!active)
            begin
               next_r.state = DEV_IDLE;
               next_r.drive = 1'b0;
            end
         end
         default:
            next_r.state = DEV_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         r <= '0;
      else
         r <= next_r;
   end

   // ---------------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------------
   // Wait until done.
   assign wait_active = active && (r.state != DEV_DONE);
   assign bus.wait_out = r.wait_hi ? wait_active : !wait_active;
   assign bus.dev_data_out = r.rdata;
   assign bus.dev_data_oe = r.drive && !bus.chip_sel_n && !bus.read_en_n;
   assign core_req = r.core_req;
   assign core_mem_sel = r.mem_sel;
   assign core_write = r.write;
   assign core_addr = r.addr;
   assign core_lanes = r.lanes;
   assign core_wdata = r.wdata;
   assign mode_ok = r.mode_ok;
   assign cfg_taken = r.cfg_taken;

endmodule : ihb_device

/* File: logic/ihb_host.sv */
`timescale 1ns/100ps
module ihb_host
   import ihb_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   ihb_if.host bus,
   input wire logic [7:0] sw_addr,
   input wire logic [31:0] sw_wdata,
   input wire logic sw_write,
   input wire logic sw_read,
   output logic [31:0] sw_rdata
);

   typedef struct packed {
      ihb_host_state_t state;
      logic [2:0] cnt;
      logic [17:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic read_op;
      logic byte_op;
      logic wait_hi;
      logic done;
      logic cs_n;
      logic rd_n;
      logic wr_n;
      logic drive;
      logic [31:0] sw_rdata;
   } ihb_host_regs_t;

   ihb_host_regs_t r;
   ihb_host_regs_t next_r;
   logic waiting;
   logic start;
   logic clear_done;

   assign waiting = r.wait_hi ? bus.wait_out : !bus.wait_out;
   assign start = sw_write && (sw_addr == HREG_CTRL) &&
                  sw_wdata[CTRL_START_BIT] && (r.state == H_IDLE);
   assign clear_done = sw_write && (sw_addr == HREG_STATUS) &&
                       sw_wdata[STATUS_DONE_BIT];

   // ---------------------------------------------------------------------
   // Command registers and bus cycle
   // ---------------------------------------------------------------------
   always_comb
   begin
      next_r = r;
      next_r.sw_rdata = 32'h00000000;
      if (sw_write && r.state == H_IDLE)
      begin
         if (sw_addr == HREG_ADDR)
            next_r.addr = sw_wdata[17:0];
         if (sw_addr == HREG_WDATA)
            next_r.wdata = sw_wdata[15:0];
         if (sw_addr == HREG_CTRL)
         begin
            next_r.read_op = sw_wdata[CTRL_READ_BIT];
            next_r.byte_op = sw_wdata[CTRL_BYTE_BIT];
            next_r.wait_hi = sw_wdata[CTRL_WAIT_HI_BIT];
         end
      end
      if (sw_read)
      begin
         unique case (sw_addr)
            HREG_ADDR: next_r.sw_rdata = {14'h0, r.addr};
            HREG_WDATA: next_r.sw_rdata = {16'h0000, r.wdata};
            HREG_RDATA: next_r.sw_rdata = {16'h0000, r.rdata};
            HREG_CTRL: next_r.sw_rdata = {28'h0000000, r.wait_hi,
                                          r.byte_op, r.read_op, 1'b0};
            HREG_STATUS: next_r.sw_rdata = {30'h0, r.done,
                                            r.state != H_IDLE};
            default: next_r.sw_rdata = 32'h00000000;
         endcase
      end
      // A completion in the same cycle as a clear keeps the flag set.
      next_r.done = r.done && !clear_done;
      if (r.cnt != 3'h0)
         next_r.cnt = r.cnt - 3'h1;
      unique case (r.state)
         H_IDLE:
            if (start)
            begin
               next_r.state = H_SETUP;
               next_r.cs_n = 1'b0;
               next_r.drive = !sw_wdata[CTRL_READ_BIT];
               next_r.cnt = SETUP_CYCLES;
            end
         H_SETUP:
            if (r.cnt <= 3'h1)
            begin
               next_r.state = H_STROBE;
               next_r.rd_n = !r.read_op;
               next_r.wr_n = r.read_op;
               next_r.cnt = STROBE_CYCLES;
            end
         H_STROBE:
            if (r.cnt <= 3'h1 && !waiting)
            begin
               next_r.state = H_RELEASE;
               next_r.rd_n = 1'b1;
               next_r.wr_n = 1'b1;
               if (r.read_op)
                  next_r.rdata = bus.data_io;
            end
         H_RELEASE:
         begin
            next_r.state = H_RECOVER;
            next_r.cs_n = 1'b1;
            next_r.drive = 1'b0;
            next_r.cnt = RECOVERY_CYCLES;
         end
         H_RECOVER:
            if (r.cnt <= 3'h1)
            begin
               next_r.state = H_IDLE;
               next_r.done = 1'b1;
            end
         default:
            next_r.state = H_IDLE;
      endcase
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
         r <= '{state: H_IDLE, cnt: 3'h0, addr: ADDR_RESET,
                wdata: DATA_RESET, rdata: DATA_RESET, read_op: 1'b0,
                byte_op: 1'b0, wait_hi: 1'b0, done: 1'b0, cs_n: 1'b1,
                rd_n: 1'b1, wr_n: 1'b1, drive: 1'b0,
                sw_rdata: 32'h00000000};
      else
         r <= next_r;
   end

   // ---------------------------------------------------------------------
   // Bus pins
   // ---------------------------------------------------------------------
   // Select held.
   assign bus.chip_sel_n = r.cs_n;
   assign bus.mem_reg_sel = r.addr[MEM_SEL_BIT];
   assign bus.addr_in = r.addr[ADDR_W-1:0];
   assign bus.high_byte_write_en_n = r.byte_op;
   assign bus.low_byte_write_en_n = r.wr_n;
   assign bus.read_en_n = r.rd_n;
   assign bus.bus_start_in = 1'b1;
   assign bus.rw_dir_in = 1'b1;
   assign bus.host_data_out = r.wdata;
   assign bus.host_data_oe = r.drive;
   assign sw_rdata = r.sw_rdata;

endmodule : ihb_host

/* File: logic/ihb_if.sv */
`timescale 1ns/100ps
interface ihb_if;
   import ihb_pkg::*;
   logic chip_sel_n;
   logic mem_reg_sel;
   logic [ADDR_W-1:0] addr_in;
   logic high_byte_write_en_n;
   logic low_byte_write_en_n;
   logic read_en_n;
   logic bus_start_in;
   logic rw_dir_in;
   logic wait_out;
   logic host_wide_ack_n;
   logic [DATA_W-1:0] host_data_out;
   logic host_data_oe;
   logic [DATA_W-1:0] dev_data_out;
   logic dev_data_oe;
   logic [DATA_W-1:0] data_io;

   // Resolved data bus; undriven lines float high.
   assign data_io = dev_data_oe ? dev_data_out :
                    host_data_oe ? host_data_out : BUS_IDLE_LEVEL;
   // Wide-transfer acknowledge is strapped to the chip select.
   assign host_wide_ack_n = chip_sel_n;

   modport device (
      input chip_sel_n, mem_reg_sel, addr_in, high_byte_write_en_n,
      input low_byte_write_en_n, read_en_n, bus_start_in, rw_dir_in,
      input data_io,
      output wait_out, dev_data_out, dev_data_oe
   );
   modport host (
      output chip_sel_n, mem_reg_sel, addr_in, high_byte_write_en_n,
      output low_byte_write_en_n, read_en_n, bus_start_in, rw_dir_in,
      output host_data_out, host_data_oe,
      input wait_out, host_wide_ack_n, data_io
   );
endinterface : ihb_if

/* File: logic/ihb_pkg.sv */
package ihb_pkg;

   // ---------------------------------------------------------------------
   // Bus widths and decode
   // ---------------------------------------------------------------------
   localparam int ADDR_W = 17;
   localparam int DATA_W = 16;
   localparam int MEM_SEL_BIT = 17;
   localparam logic [3:0] MODE_GENERIC2_LE = 4'h4;
   localparam logic CFG_RESERVED_LEVEL = 1'b1;
   localparam logic [15:0] BUS_IDLE_LEVEL = 16'hFFFF;

   // ---------------------------------------------------------------------
   // Clock and host cycle timing
   // ---------------------------------------------------------------------
   localparam int CLOCK_PERIOD_NS = 100;
   localparam int SETUP_TIME_NS = 100;
   localparam int STROBE_MIN_NS = 200;
   localparam int RECOVERY_NS = 100;
   localparam logic [2:0] SETUP_CYCLES =
      3'((SETUP_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [2:0] STROBE_CYCLES =
      3'((STROBE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
   localparam logic [2:0] RECOVERY_CYCLES =
      3'((RECOVERY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);

   // ---------------------------------------------------------------------
   // Host controller registers
   // ---------------------------------------------------------------------
   localparam logic [7:0] HREG_ADDR = 8'h00;
   localparam logic [7:0] HREG_WDATA = 8'h04;
   localparam logic [7:0] HREG_RDATA = 8'h08;
   localparam logic [7:0] HREG_CTRL = 8'h0C;
   localparam logic [7:0] HREG_STATUS = 8'h10;
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_READ_BIT = 1;
   localparam int CTRL_BYTE_BIT = 2;
   localparam int CTRL_WAIT_HI_BIT = 3;
   localparam int STATUS_BUSY_BIT = 0;
   localparam int STATUS_DONE_BIT = 1;
   localparam logic [17:0] ADDR_RESET = 18'h00000;
   localparam logic [15:0] DATA_RESET = 16'h0000;

   // ---------------------------------------------------------------------
   // State types
   // ---------------------------------------------------------------------
   typedef enum logic [1:0] {DEV_IDLE, DEV_ARB, DEV_DONE} ihb_dev_state_t;
   typedef enum logic [1:0] {OWN_NONE, OWN_HOST, OWN_REFRESH} ihb_owner_t;
   typedef enum logic [2:0] {
      H_IDLE, H_SETUP, H_STROBE, H_RELEASE, H_RECOVER
   } ihb_host_state_t;

   // Lane enables: bit 1 high lane, bit 0 low lane.
   function automatic logic [1:0] ihb_lanes(input logic wide_n,
                                            input logic a0);
      if (!wide_n)
         return 2'h3;
      return a0 ? 2'h2 : 2'h1;
   endfunction : ihb_lanes

endpackage : ihb_pkg

/* File: test/ihb_props.sv */
`timescale 1ns/100ps
module ihb_props
(
   input wire logic clock,
   input wire logic rst,
   input wire logic wait_polarity_cfg,
   input wire logic chip_sel_n,
   input wire logic low_byte_write_en_n,
   input wire logic read_en_n,
   input wire logic bus_start_in,
   input wire logic rw_dir_in,
   input wire logic wait_out,
   input wire logic host_wide_ack_n,
   input wire logic dev_data_oe
);
   // -----------------------
   // Host bus protocol checks
   // -----------------------
   logic [1:0] age;
   logic settled;
   logic wait_act;
   // The polarity strap is latched only after release, so skip early edges.
   assign settled = (age == 2'h3);
   assign wait_act = wait_polarity_cfg ? wait_out : !wait_out;
   always_ff @(posedge clock or posedge rst)
      if (rst)
         age <= 2'h0;
      else if (!settled)
         age <= age + 2'h1;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   sequence s_strobe_start;
      settled && !chip_sel_n &&
         ($fell(low_byte_write_en_n) || $fell(read_en_n));
   endsequence
   sequence s_read_done;
      wait_act ##1 (!wait_act && !read_en_n && !chip_sel_n);
   endsequence
   a_deselect_quiet: assert property (chip_sel_n |-> !dev_data_oe)
      else $error("data driven while deselected");
   a_read_drive_only: assert property (dev_data_oe |-> !read_en_n)
      else $error("data driven outside a read");
   a_idle_no_wait: assert property (
      settled && chip_sel_n |-> !wait_act)
      else $error("wait active while deselected");
   a_wait_on_strobe: assert property (s_strobe_start |-> wait_act)
      else $error("no wait at strobe start");
   a_wait_bounded: assert property (
      settled && wait_act |-> ##[1:40] !wait_act)
      else $error("wait never released");
   a_host_extends: assert property (
      settled && wait_act && !chip_sel_n
      |=> $stable({low_byte_write_en_n, read_en_n}))
      else $error("strobe moved during wait");
   a_read_data_out: assert property (s_read_done |-> dev_data_oe)
      else $error("read data missing after wait");
   a_select_covers: assert property (
      !(low_byte_write_en_n && read_en_n) |-> !chip_sel_n)
      else $error("strobe without chip select");
   a_strobe_single: assert property (
      !low_byte_write_en_n |-> read_en_n)
      else $error("both strobes low");
   a_unused_high: assert property (bus_start_in && rw_dir_in)
      else $error("unused inputs not high");
   a_wide_ack: assert property (host_wide_ack_n == chip_sel_n)
      else $error("wide acknowledge differs from select");
endmodule : ihb_props

/* File: test/ihb_test.sv */
`timescale 1ns/100ps
`define CHK(what, exp, got) \
   begin \
      checks++; \
      if ((got) !== (exp)) \
      begin \
         bad_count++; \
         $display("ERROR %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module ihb_test;
   import ihb_pkg::*;
   // -----------------------
   // Bench signals and parts
   // -----------------------
   logic clock, rst, wait_pol, ratio, refresh_req, refresh_grant, refresh_on;
   logic core_req, core_mem_sel, core_write, core_ack, mode_ok, cfg_taken;
   logic [3:0] mode;
   logic [16:0] core_addr, last_addr;
   logic [1:0] core_lanes, last_lanes;
   logic [15:0] core_wdata, core_rdata, last_wdata, d16;
   logic [7:0] sw_addr;
   logic [31:0] sw_wdata, sw_rdata, rv;
   logic sw_write, sw_read, last_sel, last_wr;
   logic [15:0] mem [0:31];
   logic [4:0] idx;
   int checks, bad_count, ack_delay, dly_cnt, grants;
   ihb_if bus();
   ihb_device ihb_device_inst (.clock(clock), .rst(rst), .bus(bus.device),
      .cfg_pin_0(mode[0]), .cfg_pin_1(mode[1]), .cfg_pin_2(mode[2]),
      .cfg_reserved_pin(1'b1), .cfg_pin_4(mode[3]),
      .wait_polarity_cfg(wait_pol), .clock_ratio_cfg(ratio),
      .refresh_req(refresh_req), .refresh_grant(refresh_grant),
      .core_req(core_req), .core_mem_sel(core_mem_sel),
      .core_write(core_write), .core_addr(core_addr),
      .core_lanes(core_lanes), .core_wdata(core_wdata),
      .core_rdata(core_rdata), .core_ack(core_ack), .mode_ok(mode_ok),
      .cfg_taken(cfg_taken));
   ihb_host ihb_host_inst (.clock(clock), .rst(rst), .bus(bus.host),
      .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write),
      .sw_read(sw_read), .sw_rdata(sw_rdata));
   ihb_props ihb_props_inst (.clock(clock), .rst(rst),
      .wait_polarity_cfg(wait_pol), .chip_sel_n(bus.chip_sel_n),
      .low_byte_write_en_n(bus.low_byte_write_en_n),
      .read_en_n(bus.read_en_n), .bus_start_in(bus.bus_start_in),
      .rw_dir_in(bus.rw_dir_in), .wait_out(bus.wait_out),
      .host_wide_ack_n(bus.host_wide_ack_n), .dev_data_oe(bus.dev_data_oe));
   assign idx = {core_mem_sel, core_addr[4:1]};
   initial
   begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   // The core answers after a chosen delay; refresh re-requests when on.
   always @(posedge clock)
   begin
      core_ack <= 1'b0;
      refresh_req <= refresh_grant ? 1'b0 : refresh_on;
      if (refresh_grant)
         grants++;
      if (core_req && !core_ack && dly_cnt < ack_delay)
         dly_cnt++;
      else if (core_req && !core_ack)
      begin
         dly_cnt = 0;
         core_ack <= 1'b1;
         core_rdata <= mem[idx];
         {last_sel, last_wr, last_addr} = {core_mem_sel, core_write, core_addr};
         {last_lanes, last_wdata} = {core_lanes, core_wdata};
         if (core_write && core_lanes[0])
            mem[idx][7:0] = core_wdata[7:0];
         if (core_write && core_lanes[1])
            mem[idx][15:8] = core_wdata[15:8];
      end
   end
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : summarize
   task automatic do_reset(input logic [3:0] m, input logic p, input logic r);
      @(posedge clock);
      rst <= 1'b1;
      {mode, wait_pol, ratio} <= {m, p, r};
      repeat (10) @(posedge clock);
      rst <= 1'b0;
      repeat (3) @(posedge clock);
      #1;
   endtask : do_reset
   task automatic sw_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      sw_addr <= a;
      sw_wdata <= d;
      sw_write <= 1'b1;
      @(posedge clock);
      sw_write <= 1'b0;
   endtask : sw_wr
   task automatic sw_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clock);
      sw_addr <= a;
      sw_read <= 1'b1;
      @(posedge clock);
      sw_read <= 1'b0;
      #1;
      d = sw_rdata;
   endtask : sw_rd
   task automatic access(input logic [17:0] a, input logic [15:0] wd,
                         input logic rd, input logic b8,
                         output logic [15:0] q);
      logic [31:0] st;
      int n;
      st = 32'h0;
      sw_wr(HREG_ADDR, {14'h0, a});
      sw_wr(HREG_WDATA, {16'h0, wd});
      sw_wr(HREG_CTRL, {28'h0, wait_pol, b8, rd, 1'b1});
      sw_rd(HREG_STATUS, st);
      `CHK("busy", 1'b1, st[STATUS_BUSY_BIT])
      for (n = 0; n < 80 && st[STATUS_DONE_BIT] !== 1'b1; n++)
         sw_rd(HREG_STATUS, st);
      if (st[STATUS_DONE_BIT] !== 1'b1)
      begin
         bad_count++;
         summarize();
      end
      sw_wr(HREG_STATUS, 32'h2);
      sw_rd(HREG_RDATA, st);
      q = st[15:0];
   endtask : access
   initial
   begin
      {rst, mode, wait_pol, ratio, refresh_on} = {1'b1, 4'h4, 3'h0};
      {refresh_req, core_ack, core_rdata, sw_write, sw_read} = '0;
      {sw_addr, sw_wdata} = '0;
      {checks, bad_count, ack_delay, dly_cnt, grants} = '0;
      for (int i = 0; i < 32; i++)
         mem[i] = 16'h0;
      for (int c = 0; c < 16; c++)
      begin
         do_reset(c[3:0], 1'b0, 1'b0);
         `CHK("cfg taken", 1'b1, cfg_taken)
         `CHK("mode ok", 1'(c == 4), mode_ok)
      end
      for (int k = 0; k < 4; k++)
      begin
         do_reset(4'h4, k[0], k[1]);
         `CHK("idle wait", ~k[0], bus.wait_out)
         access({1'b0, 17'h00010}, 16'(16'hA55A + k), 1'b0, 1'b0,
            d16);
         `CHK("core write", 1'b1, last_wr)
         `CHK("reg block", 1'b0, last_sel)
         `CHK("wide lanes", 2'h3, last_lanes)
         `CHK("wide data", 16'(16'hA55A + k), last_wdata)
         access({1'b0, 17'h00010}, 16'h0, 1'b1, 1'b0, d16);
         `CHK("core read", 1'b0, last_wr)
         `CHK("reg read", 16'(16'hA55A + k), d16)
      end
      access({1'b1, 17'h1FFFE}, 16'h1234, 1'b0, 1'b0, d16);
      `CHK("buffer block", 1'b1, last_sel)
      `CHK("top address", 17'h1FFFE, last_addr)
      access({1'b1, 17'h1FFFE}, 16'h0, 1'b1, 1'b0, d16);
      `CHK("buffer read", 16'h1234, d16)
      access({1'b1, 17'h00020}, 16'h00C3, 1'b0, 1'b1, d16);
      `CHK("even lanes", 2'h1, last_lanes)
      `CHK("even byte", 8'hC3, last_wdata[7:0])
      access({1'b1, 17'h00021}, 16'h007E, 1'b0, 1'b1, d16);
      `CHK("odd lanes", 2'h2, last_lanes)
      `CHK("odd data", 16'h7E7E, last_wdata)
      `CHK("odd address", 17'h00020, last_addr)
      access({1'b1, 17'h00020}, 16'h0, 1'b1, 1'b0, d16);
      `CHK("merged word", 16'h7EC3, d16)
      access({1'b1, 17'h00021}, 16'h0, 1'b1, 1'b1, d16);
      `CHK("odd byte read", 8'h7E, d16[7:0])
      // Slow core and steady refresh stretch the wait phase.
      ack_delay = 3;
      refresh_on = 1'b1;
      access({1'b0, 17'h00012}, 16'h5AA5, 1'b0, 1'b0, d16);
      access({1'b0, 17'h00012}, 16'h0, 1'b1, 1'b0, d16);
      `CHK("shared read", 16'h5AA5, d16)
      `CHK("refresh served", 1'b1, 1'(grants > 0))
      refresh_on = 1'b0;
      sw_rd(HREG_STATUS, rv);
      `CHK("done cleared", 1'b0, rv[STATUS_DONE_BIT])
      sw_rd(8'h3C, rv);
      `CHK("unmapped read", 32'h0, rv)
      summarize();
   end
endmodule : ihb_test
